// File: design/tsrr_pkg.sv
// Constants shared by the temperature result readout block.
// Assumes an 8-bit command code space, one register per code.
package tsrr_pkg;

   localparam logic [7:0] LOCAL_INT_OFS   = 8'h10;
   localparam logic [7:0] REMOTE1_INT_OFS = 8'h11;
   localparam logic [7:0] REMOTE2_INT_OFS = 8'h12;
   localparam logic [7:0] LOCAL_FRAC_OFS  = 8'h20;
   localparam logic [7:0] REMOTE1_FRAC_OFS = 8'h21;
   localparam logic [7:0] REMOTE2_FRAC_OFS = 8'h22;
   localparam logic [7:0] MAKER_ID_OFS    = 8'hfe;
   localparam logic [7:0] DIE_REV_OFS     = 8'hff;

   // Conversion codes are signed, 0.125 degree per count
   localparam int         TEMP_W          = 12;
   localparam logic signed [11:0] SIGNED_MAX   = 12'sh3ff;
   localparam logic signed [11:0] SIGNED_MIN   = -12'sh400;

   // Fraction bits that exist; the rest read as zero
   localparam logic [7:0] LOCAL_FRAC_MASK  = 8'hc0;
   localparam logic [7:0] REMOTE_FRAC_MASK = 8'he0;

   // Readings reported when a remote diode is missing
   localparam logic [15:0] ABSENT_UNSIGNED = 16'hffe0;
   localparam logic [15:0] ABSENT_SIGNED   = 16'h8000;

   localparam logic [7:0] RESULT_RESET    = 8'h00;
   localparam logic [7:0] UNMAPPED_READ   = 8'h00;

   // Arbitrary identity values, not those of any real part
   localparam logic [7:0] MAKER_ID_DEFAULT = 8'h5a;
   localparam logic [7:0] DIE_REV_DEFAULT  = 8'h00;

   typedef enum logic [1:0] {
      TSRR_CH_LOCAL,
      TSRR_CH_REMOTE1,
      TSRR_CH_REMOTE2,
      TSRR_CH_NONE
   } tsrr_chan_t;

endpackage

// File: design/tsrr_chan.sv
// One channel of result storage: integer byte, fraction byte and the lock.
// Assumes reads and conversion loads arrive as single-cycle pulses.
`timescale 1ns/100ps
module tsrr_chan #(
   parameter logic [7:0] FRAC_MASK = tsrr_pkg::REMOTE_FRAC_MASK
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        load,
   input  wire logic [15:0] load_word,
   input  wire logic        int_rd,
   input  wire logic        frac_rd,
   output logic [7:0]       int_byte,
   output logic [7:0]       frac_byte,
   output logic [7:0]       latest_frac,
   output logic             frozen
);

   logic [7:0] int_ff;
   logic [7:0] latest_ff;
   logic [7:0] held_ff;
   logic       frozen_ff;

   always_ff @(posedge clk) begin
      if (rst) begin
         int_ff    <= tsrr_pkg::RESULT_RESET;
         latest_ff <= tsrr_pkg::RESULT_RESET;
      end else if (load) begin
         int_ff    <= load_word[15:8];
         latest_ff <= load_word[7:0] & FRAC_MASK;
      end
   end

   // The held copy always comes from the newest conversion, so a second
   // integer read without a fraction read overwrites the old pair.
   always_ff @(posedge clk) begin
      if (rst) begin
         held_ff <= tsrr_pkg::RESULT_RESET;
      end else if (int_rd) begin
         held_ff <= latest_ff;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         frozen_ff <= 1'b0;
      end else if (int_rd) begin
         frozen_ff <= 1'b1;
      end else if (frac_rd) begin
         frozen_ff <= 1'b0;
      end
   end

   assign int_byte    = int_ff;
   assign frac_byte   = frozen_ff ? held_ff : latest_ff;
   assign latest_frac = latest_ff;
   assign frozen      = frozen_ff;

endmodule

// File: design/tsrr_readout.sv
// Result and identification registers of a three-channel temperature sensor.
// Assumes a serial bus front end that turns host transfers into command-code
// read and write strobes, and a converter that pulses one result at a time.
// How it works
// - Local integer byte: sign in bit 7, weights 64 down to 1 below.
// - Local fraction byte: 0.5 and 0.25 in bits 7,6; rest zero.
// - Remote signed integer byte: sign in bit 7, weights 64 to 1.
// - Remote unsigned integer byte: plain binary, 128 down to 1.
// - Remote fraction byte: 0.5, 0.25, 0.125 in bits 7..5; rest zero.
// - Reading an integer byte freezes that channel's fraction byte.
// - Reading a fraction byte releases its freeze.
// - Every integer read re-captures the fraction, replacing an older frozen one.
// - Maker identification byte at FEh, fixed value.
// - Die revision byte at FFh, bumped per silicon revision.
// - Per-remote format select: zero unsigned 0..255.875, one signed.
// - Missing remote diode reads FFE0h unsigned or 8000h signed.
`timescale 1ns/100ps
module tsrr_readout #(
   parameter logic [7:0] MAKER_ID = tsrr_pkg::MAKER_ID_DEFAULT,
   parameter logic [7:0] DIE_REV  = tsrr_pkg::DIE_REV_DEFAULT
) (
   input  wire logic        SYS_CLK,
   input  wire logic        RST,
   input  wire logic [7:0]  CMD_CODE,
   input  wire logic        RD_STB,
   input  wire logic        WR_STB,
   input  wire logic [7:0]  WR_DATA,
   output logic [7:0]       RD_DATA,
   output logic             RD_VALID,
   input  wire logic        CONV_DONE,
   input  wire logic [1:0]  CONV_CHAN,
   input  wire logic [11:0] CONV_TEMP,
   input  wire logic        REMOTE_ONE_FORMAT_SELECT,
   input  wire logic        REMOTE_TWO_FORMAT_SELECT,
   input  wire logic        REMOTE_ONE_DIODE_ABSENT,
   input  wire logic        REMOTE_TWO_DIODE_ABSENT
);

   // Turns a signed 0.125-degree code into {integer byte, fraction byte}.
   // Out-of-range codes saturate rather than wrap, so a hot die never
   // reads as cold.
   function automatic logic [15:0] fmt_word(input logic signed [11:0] t,
                                            input logic              is_signed,
                                            input logic              absent);
      logic signed [11:0] c;
      c = t;
      if (is_signed) begin
         if (t > tsrr_pkg::SIGNED_MAX) begin
            c = tsrr_pkg::SIGNED_MAX;
         end else if (t < tsrr_pkg::SIGNED_MIN) begin
            c = tsrr_pkg::SIGNED_MIN;
         end
      end else if (t < 12'sh000) begin
         c = 12'sh000;
      end
      if (absent) begin
         fmt_word = is_signed ? tsrr_pkg::ABSENT_SIGNED
                              : tsrr_pkg::ABSENT_UNSIGNED;
      end else begin
         fmt_word = {c[10:0], 5'h00};
      end
   endfunction

   function automatic logic is_cmd(input logic [7:0] code, input logic [7:0] ofs);
      is_cmd = (code == ofs);
   endfunction

   logic [15:0] local_word;
   logic [15:0] r1_word;
   logic [15:0] r2_word;
   logic [2:0]  load;
   logic [2:0]  int_rd;
   logic [2:0]  frac_rd;
   logic [7:0]  int_byte  [3];
   logic [7:0]  frac_byte [3];
   logic [7:0]  latest    [3];
   logic [2:0]  frozen;
   logic [7:0]  nxt_rd_data;
   logic [7:0]  rd_data_ff;
   logic        rd_valid_ff;

   // Local channel is always signed and never reported missing
   assign local_word = fmt_word(CONV_TEMP, 1'b1, 1'b0);
   assign r1_word    = fmt_word(CONV_TEMP, REMOTE_ONE_FORMAT_SELECT,
                                REMOTE_ONE_DIODE_ABSENT);
   assign r2_word    = fmt_word(CONV_TEMP, REMOTE_TWO_FORMAT_SELECT,
                                REMOTE_TWO_DIODE_ABSENT);

   always_comb begin
      load = 3'h0;
      if (CONV_DONE) begin
         case (tsrr_pkg::tsrr_chan_t'(CONV_CHAN))
            tsrr_pkg::TSRR_CH_LOCAL:   load = 3'h1;
            tsrr_pkg::TSRR_CH_REMOTE1: load = 3'h2;
            tsrr_pkg::TSRR_CH_REMOTE2: load = 3'h4;
            default:                   load = 3'h0;
         endcase
      end
   end

   always_comb begin
      int_rd  = 3'h0;
      frac_rd = 3'h0;
      if (RD_STB) begin
         int_rd[0]  = is_cmd(CMD_CODE, tsrr_pkg::LOCAL_INT_OFS);
         int_rd[1]  = is_cmd(CMD_CODE, tsrr_pkg::REMOTE1_INT_OFS);
         int_rd[2]  = is_cmd(CMD_CODE, tsrr_pkg::REMOTE2_INT_OFS);
         frac_rd[0] = is_cmd(CMD_CODE, tsrr_pkg::LOCAL_FRAC_OFS);
         frac_rd[1] = is_cmd(CMD_CODE, tsrr_pkg::REMOTE1_FRAC_OFS);
         frac_rd[2] = is_cmd(CMD_CODE, tsrr_pkg::REMOTE2_FRAC_OFS);
      end
   end

   tsrr_chan #(
      .FRAC_MASK (tsrr_pkg::LOCAL_FRAC_MASK)
   ) u_local (
      .clk         (SYS_CLK),
      .rst         (RST),
      .load        (load[0]),
      .load_word   (local_word),
      .int_rd      (int_rd[0]),
      .frac_rd     (frac_rd[0]),
      .int_byte    (int_byte[0]),
      .frac_byte   (frac_byte[0]),
      .latest_frac (latest[0]),
      .frozen      (frozen[0])
   );

   tsrr_chan #(
      .FRAC_MASK (tsrr_pkg::REMOTE_FRAC_MASK)
   ) u_remote1 (
      .clk         (SYS_CLK),
      .rst         (RST),
      .load        (load[1]),
      .load_word   (r1_word),
      .int_rd      (int_rd[1]),
      .frac_rd     (frac_rd[1]),
      .int_byte    (int_byte[1]),
      .frac_byte   (frac_byte[1]),
      .latest_frac (latest[1]),
      .frozen      (frozen[1])
   );

   tsrr_chan #(
      .FRAC_MASK (tsrr_pkg::REMOTE_FRAC_MASK)
   ) u_remote2 (
      .clk         (SYS_CLK),
      .rst         (RST),
      .load        (load[2]),
      .load_word   (r2_word),
      .int_rd      (int_rd[2]),
      .frac_rd     (frac_rd[2]),
      .int_byte    (int_byte[2]),
      .frac_byte   (frac_byte[2]),
      .latest_frac (latest[2]),
      .frozen      (frozen[2])
   );

   // Read data is the value before this cycle's lock takes effect, so an
   // integer read returns the byte that pairs with the fraction it holds.
   always_comb begin
      case (CMD_CODE)
         tsrr_pkg::LOCAL_INT_OFS:    nxt_rd_data = int_byte[0];
         tsrr_pkg::REMOTE1_INT_OFS:  nxt_rd_data = int_byte[1];
         tsrr_pkg::REMOTE2_INT_OFS:  nxt_rd_data = int_byte[2];
         tsrr_pkg::LOCAL_FRAC_OFS:   nxt_rd_data = frac_byte[0];
         tsrr_pkg::REMOTE1_FRAC_OFS: nxt_rd_data = frac_byte[1];
         tsrr_pkg::REMOTE2_FRAC_OFS: nxt_rd_data = frac_byte[2];
         tsrr_pkg::MAKER_ID_OFS:     nxt_rd_data = MAKER_ID;
         tsrr_pkg::DIE_REV_OFS:      nxt_rd_data = DIE_REV;
         default:                    nxt_rd_data = tsrr_pkg::UNMAPPED_READ;
      endcase
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         rd_data_ff <= tsrr_pkg::RESULT_RESET;
      end else if (RD_STB) begin
         rd_data_ff <= nxt_rd_data;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         rd_valid_ff <= 1'b0;
      end else begin
         rd_valid_ff <= RD_STB;
      end
   end

   // No write path exists: WR_STB and WR_DATA reach no storage.
   assign RD_DATA  = rd_data_ff;
   assign RD_VALID = rd_valid_ff;

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);

   chk_int_rd_freeze: assert property (int_rd[1] |=> frozen[1])
      else $error("Remote one fraction not frozen after integer read");

   chk_frac_rd_unlock: assert property (frac_rd[2] |=> !frozen[2])
      else $error("Remote two fraction still frozen after its read");

   chk_frozen_holds: assert property (frozen[0] && !int_rd[0] && !frac_rd[0]
                                      |=> $stable(frac_byte[0]))
      else $error("Frozen local fraction changed");

   chk_recapture_new: assert property (int_rd[1] |=> frac_byte[1] == $past(latest[1]))
      else $error("Integer read did not capture the newest fraction");

   chk_local_frac_zero: assert property (RD_STB && CMD_CODE == tsrr_pkg::LOCAL_FRAC_OFS
                                         |=> RD_DATA[5:0] == 6'h00)
      else $error("Local fraction low bits not zero");

   chk_remote_frac_zero: assert property (RD_STB && CMD_CODE == tsrr_pkg::REMOTE2_FRAC_OFS
                                          |=> RD_DATA[4:0] == 5'h00)
      else $error("Remote fraction low bits not zero");

   chk_maker_id_read: assert property (RD_STB && CMD_CODE == tsrr_pkg::MAKER_ID_OFS
                                       |=> RD_VALID && RD_DATA == MAKER_ID)
      else $error("Maker identification read wrong");

   chk_die_rev_read: assert property (RD_STB && CMD_CODE == tsrr_pkg::DIE_REV_OFS
                                      |=> RD_VALID && RD_DATA == DIE_REV)
      else $error("Die revision read wrong");

   chk_absent_code: assert property (load[1] && REMOTE_ONE_DIODE_ABSENT
                                     && !REMOTE_ONE_FORMAT_SELECT && !frozen[1]
                                     |=> int_byte[1] == 8'hff && frac_byte[1] == 8'he0)
      else $error("Missing diode code wrong in unsigned format");

   chk_signed_clamp: assert property (load[2] && REMOTE_TWO_FORMAT_SELECT
                                      && !REMOTE_TWO_DIODE_ABSENT
                                      && $signed(CONV_TEMP) > tsrr_pkg::SIGNED_MAX
                                      |=> int_byte[2] == 8'h7f)
      else $error("Signed remote reading did not saturate");

   chk_unsigned_floor: assert property (load[1] && !REMOTE_ONE_FORMAT_SELECT
                                        && !REMOTE_ONE_DIODE_ABSENT && CONV_TEMP[11]
                                        |=> int_byte[1] == 8'h00)
      else $error("Unsigned remote reading went below zero");

   chk_local_update: assert property (load[0] |=> int_byte[0] == $past(local_word[15:8]))
      else $error("Local integer byte not updated by conversion");

   chk_write_ignored: assert property (WR_STB && !CONV_DONE
                                       |=> $stable(int_byte[0]) && $stable(int_byte[1])
                                           && $stable(int_byte[2]))
      else $error("Write changed a result register");

   // Expectations below come straight from the conversion code, for codes that
   // need no saturation, so they do not lean on the formatting function.
   chk_local_int_map: assert property (load[0] && CONV_TEMP[11] == CONV_TEMP[10]
                                       |=> int_byte[0] == $past(CONV_TEMP[10:3]))
      else $error("Local integer byte does not carry the conversion");

   chk_local_frac_map: assert property (
      load[0] && !frozen[0] && CONV_TEMP[11] == CONV_TEMP[10]
      |=> frac_byte[0] == {$past(CONV_TEMP[2:1]), 6'h00})
      else $error("Local fraction byte does not carry the conversion");

   chk_remote_unsigned_map: assert property (
      load[2] && !REMOTE_TWO_FORMAT_SELECT && !REMOTE_TWO_DIODE_ABSENT
      && !CONV_TEMP[11] && !frozen[2]
      |=> int_byte[2] == $past(CONV_TEMP[10:3])
          && frac_byte[2] == {$past(CONV_TEMP[2:0]), 5'h00})
      else $error("Unsigned remote two reading does not carry the conversion");

   chk_remote_signed_map: assert property (
      load[2] && REMOTE_TWO_FORMAT_SELECT && !REMOTE_TWO_DIODE_ABSENT
      && CONV_TEMP[11] == CONV_TEMP[10] && !frozen[2]
      |=> int_byte[2] == $past(CONV_TEMP[10:3])
          && frac_byte[2] == {$past(CONV_TEMP[2:0]), 5'h00})
      else $error("Signed remote two reading does not carry the conversion");

   chk_absent_signed: assert property (
      load[1] && REMOTE_ONE_DIODE_ABSENT && REMOTE_ONE_FORMAT_SELECT && !frozen[1]
      |=> int_byte[1] == 8'h80 && frac_byte[1] == 8'h00)
      else $error("Missing diode code wrong in signed format");

   chk_local_freeze: assert property (int_rd[0] |=> frozen[0])
      else $error("Local fraction not frozen after integer read");

   chk_remote_holds: assert property (
      frozen[1] && !int_rd[1] && !frac_rd[1] |=> $stable(frac_byte[1]))
      else $error("Frozen remote one fraction changed");

   chk_live_frac_read: assert property (frac_rd[1] && !frozen[1]
                                        |=> RD_DATA == $past(latest[1]))
      else $error("Unlocked fraction read did not return the newest value");

   chk_chan_ignored: assert property (CONV_DONE && CONV_CHAN == 2'h3
      |=> $stable(int_byte[0]) && $stable(int_byte[1]) && $stable(int_byte[2]))
      else $error("Conversion for no channel changed a result");

   chk_valid_one_cycle: assert property (!RD_STB |=> !RD_VALID && $stable(RD_DATA))
      else $error("Read answer appeared without a read request");

   cov_lock_unlock: cover property (int_rd[0] ##[1:8] load[0] ##[1:8] frac_rd[0]);
   cov_chan_ignored: cover property (CONV_DONE && CONV_CHAN == 2'h3);
   cov_write_probe:  cover property (WR_STB && CMD_CODE == tsrr_pkg::MAKER_ID_OFS);
   cov_double_int:  cover property (int_rd[1] ##[1:8] load[1] ##[1:8] int_rd[1]);
   cov_absent_sgn:  cover property (load[2] && REMOTE_TWO_DIODE_ABSENT
                                    && REMOTE_TWO_FORMAT_SELECT);

endmodule

// File: verif/tsrr_host.sv
// Host-side model: issues command-code reads and writes to the readout block.
// Assumes a read is taken at one edge and answered in the cycle after it.
`timescale 1ns/100ps
module tsrr_host (
   input  wire logic       clk,
   output logic [7:0]      cmd_code,
   output logic            rd_stb,
   output logic            wr_stb,
   output logic [7:0]      wr_data,
   input  wire logic [7:0] rd_data,
   input  wire logic       rd_valid
);
   initial begin
      cmd_code = 8'h00;
      rd_stb   = 1'h0;
      wr_stb   = 1'h0;
      wr_data  = 8'h00;
   end

   // Callers read an integer byte before its fraction byte for a matched pair
   task automatic read(input logic [7:0] code, output logic [7:0] data, output logic valid);
      @(posedge clk);
      #1;
      cmd_code = code;
      rd_stb   = 1'h1;
      @(posedge clk);
      #1;
      data     = rd_data;
      valid    = rd_valid;
      rd_stb   = 1'h0;
      // Released lines show the inverse so a stale code cannot pass unseen
      cmd_code = ~code;
   endtask

   task automatic write(input logic [7:0] code, input logic [7:0] val);
      @(posedge clk);
      #1;
      cmd_code = code;
      wr_data  = val;
      wr_stb   = 1'h1;
      @(posedge clk);
      #1;
      wr_stb   = 1'h0;
      cmd_code = ~code;
      wr_data  = ~val;
   endtask
endmodule

// File: verif/tb_top.sv
// Self-checking bench for the temperature result readout block.
// Assumes the host model in tsrr_host.sv; conversions are driven here.
`timescale 1ns/100ps
module tb_top;
   // Arbitrary identity values
   localparam logic [7:0] TB_MAKER = 8'h3c;
   localparam logic [7:0] TB_REV   = 8'h02;

   typedef struct packed {
      logic [1:0]  chan;
      logic [11:0] temp;
      logic        fmt;
      logic        absent;
      logic [7:0]  e_int;
      logic [7:0]  e_frac;
   } tsrr_row_t;

   logic        sys_clk;
   logic        rst;
   logic [7:0]  cmd_code;
   logic        rd_stb;
   logic        wr_stb;
   logic [7:0]  wr_data;
   logic [7:0]  rd_data;
   logic        rd_valid;
   logic        conv_done;
   logic [1:0]  conv_chan;
   logic [11:0] conv_temp;
   logic        fs1;
   logic        fs2;
   logic        ab1;
   logic        ab2;
   int          fail_count;
   int          samples_checked;

   // Expected bytes worked out by hand from the register layouts
   tsrr_row_t rows [10] = '{
      '{2'h0, 12'h0c8, 1'h0, 1'h0, 8'h19, 8'h00},
      '{2'h0, 12'hfff, 1'h0, 1'h0, 8'hff, 8'hc0},
      '{2'h1, 12'h7ff, 1'h1, 1'h0, 8'h7f, 8'he0},
      '{2'h1, 12'h7ff, 1'h0, 1'h0, 8'hff, 8'he0},
      '{2'h1, 12'hf00, 1'h0, 1'h0, 8'h00, 8'h00},
      '{2'h2, 12'h800, 1'h1, 1'h0, 8'h80, 8'h00},
      '{2'h2, 12'hffd, 1'h1, 1'h0, 8'hff, 8'ha0},
      '{2'h2, 12'h123, 1'h0, 1'h1, 8'hff, 8'he0},
      '{2'h1, 12'h123, 1'h1, 1'h1, 8'h80, 8'h00},
      '{2'h2, 12'h0c9, 1'h0, 1'h0, 8'h19, 8'h20}
   };

   tsrr_readout #(
      .MAKER_ID (TB_MAKER),
      .DIE_REV  (TB_REV)
   ) u_tsrr_readout (
      .SYS_CLK                  (sys_clk),
      .RST                      (rst),
      .CMD_CODE                 (cmd_code),
      .RD_STB                   (rd_stb),
      .WR_STB                   (wr_stb),
      .WR_DATA                  (wr_data),
      .RD_DATA                  (rd_data),
      .RD_VALID                 (rd_valid),
      .CONV_DONE                (conv_done),
      .CONV_CHAN                (conv_chan),
      .CONV_TEMP                (conv_temp),
      .REMOTE_ONE_FORMAT_SELECT (fs1),
      .REMOTE_TWO_FORMAT_SELECT (fs2),
      .REMOTE_ONE_DIODE_ABSENT  (ab1),
      .REMOTE_TWO_DIODE_ABSENT  (ab2)
   );

   tsrr_host u_tsrr_host (
      .clk      (sys_clk),
      .cmd_code (cmd_code),
      .rd_stb   (rd_stb),
      .wr_stb   (wr_stb),
      .wr_data  (wr_data),
      .rd_data  (rd_data),
      .rd_valid (rd_valid)
   );

   initial sys_clk = 1'h0;
   always #10 sys_clk = ~sys_clk;

   task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic chk_flag(input string name, input logic exp, input logic got);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic rd_chk(input logic [7:0] code, input logic [7:0] exp);
      logic [7:0] d;
      logic       v;
      u_tsrr_host.read(code, d, v);
      chk_flag($sformatf("valid of %h", code), 1'h1, v);
      chk_byte($sformatf("data of %h", code), exp, d);
   endtask

   task automatic conv(input logic [1:0] ch, input logic [11:0] t);
      @(posedge sys_clk);
      #1;
      conv_done = 1'h1;
      conv_chan = ch;
      conv_temp = t;
      @(posedge sys_clk);
      #1;
      conv_done = 1'h0;
      conv_temp = ~t;
   endtask

   task automatic end_sim();
      if (fail_count == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      rst = 1'h1;
      conv_done = 1'h0;
      conv_chan = 2'h0;
      conv_temp = 12'h000;
      {fs1, fs2, ab1, ab2} = 4'h0;
      fail_count = 0;
      samples_checked = 0;
      repeat (5) @(posedge sys_clk);
      #1;
      rst = 1'h0;
      rd_chk(8'h21, 8'h00);
      for (int i = 0; i < 10; i++) begin
         // The other remote is flagged absent and given the other format on purpose
         fs1 = (rows[i].chan == 2'h1) ? rows[i].fmt : ~rows[i].fmt;
         fs2 = (rows[i].chan == 2'h2) ? rows[i].fmt : ~rows[i].fmt;
         ab1 = (rows[i].chan == 2'h1) ? rows[i].absent : 1'h1;
         ab2 = (rows[i].chan == 2'h2) ? rows[i].absent : 1'h1;
         conv(rows[i].chan, rows[i].temp);
         rd_chk(tsrr_pkg::LOCAL_INT_OFS + {6'h00, rows[i].chan}, rows[i].e_int);
         rd_chk(tsrr_pkg::LOCAL_FRAC_OFS + {6'h00, rows[i].chan}, rows[i].e_frac);
      end
      // Remote two saturation, then both missing-diode codes from unlocked channels
      fs1 = 1'h0;
      fs2 = 1'h1;
      conv(2'h2, 12'h7ff);
      rd_chk(8'h12, 8'h7f);
      rd_chk(8'h22, 8'he0);
      ab2 = 1'h1;
      conv(2'h1, 12'h0c8);
      conv(2'h2, 12'h0c8);
      rd_chk(8'h11, 8'hff);
      rd_chk(8'h21, 8'he0);
      rd_chk(8'h12, 8'h80);
      rd_chk(8'h22, 8'h00);
      {fs1, fs2, ab1, ab2} = 4'h0;
      conv(2'h1, 12'h0c9);
      rd_chk(8'h11, 8'h19);
      conv(2'h1, 12'h0ca);
      rd_chk(8'h21, 8'h20);
      rd_chk(8'h21, 8'h40);
      rd_chk(8'h11, 8'h19);
      conv(2'h1, 12'h0cb);
      rd_chk(8'h11, 8'h19);
      conv(2'h1, 12'h0cc);
      rd_chk(8'h21, 8'h60);
      rd_chk(8'h21, 8'h80);
      conv(2'h3, 12'h555);
      rd_chk(8'h10, 8'hff);
      u_tsrr_host.write(8'h11, 8'ha5);
      u_tsrr_host.write(8'hfe, 8'ha5);
      rd_chk(8'h11, 8'h19);
      rd_chk(8'hfe, TB_MAKER);
      rd_chk(8'hff, TB_REV);
      rd_chk(8'h05, tsrr_pkg::UNMAPPED_READ);
      rst = 1'h1;
      repeat (2) @(posedge sys_clk);
      #1;
      rst = 1'h0;
      rd_chk(8'h11, tsrr_pkg::RESULT_RESET);
      rd_chk(8'h21, tsrr_pkg::RESULT_RESET);
      end_sim();
   end

   // Whole sequence needs about 130 cycles
   initial begin
      repeat (600) @(posedge sys_clk);
      fail_count++;
      end_sim();
   end
endmodule
